// ===== design/fail_safe_watchdog_timer.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Fail-safe 16-bit watchdog with reload and reset output
// Assumes: Control strobes are one-cycle pulses synchronous to clk_sys
// Notes:   Overflow holds the reset request until rst_n is asserted
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Watchdog runs enabled straight after every reset
// - Disable honoured only before end of initialization
// - Overflow raises internal hardware reset request
// - Overflow drives reset output pin low
// - Counter is sixteen bits wide
// - Counter clocked via divide-by-2 or divide-by-128
// - Service loads upper byte with reload value
// - Reset default: zero reload, divide by two
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module fail_safe_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int CNT_W = CNT_WIDTH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Software commands
    input wire logic service_req,
    input wire logic disable_req,
    input wire logic end_of_init_command,
    // Configuration
    input wire logic prescale_slow,
    input wire logic [RELOAD_WIDTH-1:0] watchdog_reload_value,
    // Status and reset outputs
    output logic [CNT_W-1:0] count_value,
    output logic wdt_enabled,
    output logic init_done,
    output logic hw_reset_req,
    output logic reset_output_pin_n
);

    // Elaboration checks: the logic serves only the documented geometry
    if (CNT_W != CNT_WIDTH) begin : g_width_check
        $error("fail_safe_watchdog_timer: CNT_W must be 16");
    end
    if (RELOAD_WIDTH >= CNT_W) begin : g_reload_check
        $error("fail_safe_watchdog_timer: reload must be below CNT_W");
    end
    // The fast tick is bit 0 of the divider chain
    if (DIV_FAST != 2) begin : g_fast_check
        $error("fail_safe_watchdog_timer: DIV_FAST must be 2");
    end
    // The slow tick decodes the whole divider chain as all ones
    if ((1 << PRESC_WIDTH) != DIV_SLOW) begin : g_div_check
        $error("fail_safe_watchdog_timer: DIV_SLOW must be a power of 2");
    end

    //////////////////////////////////////////////////////////////////////////
    // Prescaler
    //////////////////////////////////////////////////////////////////////////
    wdt_tick_if tick_if ();

    logic sel_ff;
    logic [RELOAD_WIDTH-1:0] reload_ff;

    // Configuration captured each cycle; reset value gives default interval
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff <= SEL_FAST;
            reload_ff <= RELOAD_RESET;
        end else begin
            sel_ff <= prescale_slow;
            reload_ff <= watchdog_reload_value;
        end
    end

    assign tick_if.div_sel = sel_ff;

    wdt_prescaler u_presc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick_if(tick_if)
    );

    //////////////////////////////////////////////////////////////////////////
    // Initialization phase
    //////////////////////////////////////////////////////////////////////////
    logic init_done_ff;

    // Sticky until reset; a disable in the same cycle still counts as early
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            init_done_ff <= 1'b0;
        end else if (end_of_init_command) begin
            init_done_ff <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Helper functions
    //////////////////////////////////////////////////////////////////////////
    // Word written by a service: reload byte over a cleared low byte
    function automatic logic [CNT_W-1:0] service_word(
        input logic [RELOAD_WIDTH-1:0] reload
    );
        service_word = {reload, {LOW_WIDTH{1'b0}}};
    endfunction : service_word

    // Last count before the wrap to zero
    function automatic logic at_wrap(input logic [CNT_W-1:0] value);
        at_wrap = &value;
    endfunction : at_wrap

    //////////////////////////////////////////////////////////////////////////
    // Operating state
    //////////////////////////////////////////////////////////////////////////
    wd_state_t state_ff;
    wd_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic overflow;
    logic tick;
    logic counting;
    logic svc_take;
    logic dis_take;

    // One prescaler tick per counter step
    assign tick = tick_if.tick;

    // Service and disable act only while the watchdog is counting
    assign counting = (state_ff == WD_RUN);
    assign svc_take = service_req && counting;
    // A disable after end of init is dropped here, so the state stays RUN
    assign dis_take = disable_req && !init_done_ff;

    // Overflow on the wrap from all ones; a service in that cycle wins
    assign overflow = counting &&
                      tick &&
                      at_wrap(cnt_ff) &&
                      !service_req;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            WD_RUN: begin
                if (overflow) begin
                    nxt_state = WD_FIRED;
                end else if (dis_take) begin
                    nxt_state = WD_OFF;
                end
                // A late disable leaves the watchdog running
            end
            WD_OFF: begin
                nxt_state = WD_OFF;
            end
            WD_FIRED: begin
                // Only the chip reset leaves this state
                nxt_state = WD_FIRED;
            end
            default: begin
                nxt_state = WD_FIRED;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= WD_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Counter
    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= CNT_RESET;
        end else if (svc_take) begin
            // A service beats a tick in the same cycle
            cnt_ff <= service_word(reload_ff);
        end else if (counting && tick) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Reset outputs
    //////////////////////////////////////////////////////////////////////////
    logic rst_req_ff;
    logic pin_high_ff;

    // Held until rst_n, so the chip reset cannot be cut short
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_req_ff <= 1'b0;
        end else if (overflow) begin
            rst_req_ff <= 1'b1;
        end
    end

    // Pin is low through reset, initialization and after an overflow, high otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_high_ff <= 1'b0;
        end else if (overflow || state_ff == WD_FIRED) begin
            pin_high_ff <= 1'b0;
        end else if (end_of_init_command) begin
            pin_high_ff <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    //////////////////////////////////////////////////////////////////////////
    assign count_value = cnt_ff;
    assign wdt_enabled = counting;
    assign init_done = init_done_ff;
    assign hw_reset_req = rst_req_ff;
    assign reset_output_pin_n = pin_high_ff;

endmodule : fail_safe_watchdog_timer

// ===== design/wdt_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the fail-safe watchdog
// Assumes: One system clock, asynchronous active-low reset
// Notes:   Prescaler and counter sizes are held here once
//////////////////////////////////////////////////////////////////////////////
package wdt_pkg;

    // Counter geometry
    localparam int CNT_WIDTH = 16;
    localparam int RELOAD_WIDTH = 8;
    localparam int LOW_WIDTH = CNT_WIDTH - RELOAD_WIDTH;

    // Prescaler ratios
    localparam int DIV_FAST = 2;
    localparam int DIV_SLOW = 128;
    localparam int PRESC_WIDTH = $clog2(DIV_SLOW);

    // Reset values
    localparam logic [CNT_WIDTH-1:0] CNT_RESET = 16'h0000;
    localparam logic [RELOAD_WIDTH-1:0] RELOAD_RESET = 8'h00;
    localparam logic [PRESC_WIDTH-1:0] PRESC_RESET = 7'h00;
    localparam logic SEL_FAST = 1'b0;
    localparam logic SEL_SLOW = 1'b1;

    // Default interval: zero reload, divide by 2, full 16-bit span
    localparam real DEFAULT_TIMEOUT_MS = 5.24;
    localparam real REF_CLK_MHZ = 25.0;
    localparam int DEFAULT_TIMEOUT_CYCLES =
        DIV_FAST * (1 << CNT_WIDTH);

    // Watchdog operating state
    typedef enum logic [1:0] {
        WD_RUN = 2'b00,
        WD_OFF = 2'b01,
        WD_FIRED = 2'b10
    } wd_state_t;

endpackage : wdt_pkg

// ===== design/wdt_tick_if.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Carrier between watchdog counter and its prescaler
// Assumes: Both ends run on clk_sys
// Notes:   tick is a one-cycle pulse
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
interface wdt_tick_if;
    logic div_sel;
    logic tick;

    modport presc (input div_sel, output tick);
    modport counter (output div_sel, input tick);
endinterface : wdt_tick_if

// ===== design/wdt_prescaler.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Divide-by-2 or divide-by-128 tick for the watchdog counter
// Assumes: div_sel is stable or changes rarely
// Notes:   Free running; a ratio change takes effect at once
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module wdt_prescaler
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Tick to counter
    wdt_tick_if.presc tick_if
);

    logic [PRESC_WIDTH-1:0] presc_ff;
    logic tick_ff;

    // Free-running divider chain
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= PRESC_RESET;
        end else begin
            presc_ff <= presc_ff + 7'h01;
        end
    end

    // Tick from bit 0 for /2 or from the whole chain for /128
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 1'b0;
        end else if (tick_if.div_sel == SEL_SLOW) begin
            tick_ff <= &presc_ff;
        end else begin
            tick_ff <= presc_ff[0];
        end
    end

    assign tick_if.tick = tick_ff;

endmodule : wdt_prescaler

// ===== tb/wdt_sva.sv
// Purpose: Port assertions for the watchdog
// Assumes: One clock domain, rst_n async low
// Notes: Bound to the top module
`timescale 1ns/100ps
module wdt_sva
    import wdt_pkg::*;
#(
    parameter int CNT_W = CNT_WIDTH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Commands
    input wire logic service_req,
    input wire logic disable_req,
    input wire logic end_of_init_command,
    input wire logic prescale_slow,
    input wire logic [RELOAD_WIDTH-1:0] watchdog_reload_value,
    // Outputs
    input wire logic [CNT_W-1:0] count_value,
    input wire logic wdt_enabled,
    input wire logic init_done,
    input wire logic hw_reset_req,
    input wire logic reset_output_pin_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Fast mode only: a slow tick may not land inside two cycles
    sequence s_full;
        wdt_enabled && count_value == 16'hffff && !service_req
            && !prescale_slow;
    endsequence
    // Reload register still holds its reset value on the first edge
    svc_load_a: assert property (
        $past(rst_n) && service_req && wdt_enabled &&
        $stable(watchdog_reload_value)
        |=> count_value == {$past(watchdog_reload_value), 8'h00})
        else $error("service load wrong");
    cnt_step_a: assert property (
        wdt_enabled && !service_req ##1 !hw_reset_req
        |-> count_value - $past(count_value) <= 1)
        else $error("count step wrong");
    off_hold_a: assert property (!wdt_enabled |=> !wdt_enabled)
        else $error("watchdog restarted");
    late_dis_a: assert property (
        init_done && disable_req && wdt_enabled && count_value < 16'hff00
        |=> wdt_enabled)
        else $error("late disable honoured");
    early_dis_a: assert property (
        !init_done && disable_req && wdt_enabled |=> !wdt_enabled)
        else $error("early disable lost");
    eoi_a: assert property (
        end_of_init_command && wdt_enabled && count_value < 16'hff00
        |=> init_done && reset_output_pin_n)
        else $error("end of init lost");
    ovf_cause_a: assert property (
        $rose(hw_reset_req) |-> $past(count_value) == 16'hffff)
        else $error("reset without overflow");
    ovf_reach_a: assert property (s_full [*2] |-> ##[0:1] hw_reset_req)
        else $error("overflow missed");
    fire_hold_a: assert property (
        hw_reset_req |=> hw_reset_req && !reset_output_pin_n && !wdt_enabled)
        else $error("reset request dropped");
endmodule : wdt_sva
bind fail_safe_watchdog_timer wdt_sva #(.CNT_W(CNT_W)) u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .service_req(service_req),
    .disable_req(disable_req), .end_of_init_command(end_of_init_command),
    .prescale_slow(prescale_slow),
    .watchdog_reload_value(watchdog_reload_value),
    .count_value(count_value), .wdt_enabled(wdt_enabled),
    .init_done(init_done), .hw_reset_req(hw_reset_req),
    .reset_output_pin_n(reset_output_pin_n));

// ===== tb/fail_safe_watchdog_timer_tb_top.sv
// Purpose: Self-checking bench for the watchdog
// Assumes: Inputs change on falling edges
// Notes: Prescaler phase is unknown, so timings allow a slack
`timescale 1ns/100ps
module fail_safe_watchdog_timer_tb_top;
    import wdt_pkg::*;
    logic clk_sys = 0, rst_n = 0, svc = 0, dis = 0, eoi = 0, slow = 0;
    logic [7:0] rel = 8'h00;
    logic [15:0] cnt;
    logic en, done, hrq, pin_n;
    int error_cnt = 0, cmp_count = 0, seed = 87689, n, exp_n;
    always #5 clk_sys = ~clk_sys;
    fail_safe_watchdog_timer u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .service_req(svc), .disable_req(dis), .end_of_init_command(eoi),
        .prescale_slow(slow), .watchdog_reload_value(rel),
        .count_value(cnt), .wdt_enabled(en), .init_done(done),
        .hw_reset_req(hrq), .reset_output_pin_n(pin_n));
    // Reference model of the command rules; the overflow instant is
    // timed by the stimulus, which then raises m_fired
    int m_en = 1, m_done = 0, m_pin = 0, m_fired = 0, m_rel = 0;
    logic [15:0] load_q[$];
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            m_en = 1;
            m_done = 0;
            m_pin = 0;
            m_fired = 0;
            m_rel = 0;
            load_q.delete();
        end else begin
            if (svc && m_en == 1 && m_fired == 0)
                load_q.push_back({8'(m_rel), 8'h00});
            if (dis && m_done == 0 && m_fired == 0)
                m_en = 0;
            if (eoi)
                m_done = 1;
            if (eoi && m_fired == 0)
                m_pin = 1;
            m_rel = rel;
        end
    end
    task automatic chk(input logic [15:0] got, input int lo, input int hi);
        cmp_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            error_cnt++;
            $display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask : chk
    task automatic chk_load();
        logic [15:0] want;
        if (load_q.size() == 0) begin
            error_cnt++;
            $display("BAD %0t no service expected", $time);
        end else begin
            want = load_q.pop_front();
            chk(cnt, want, want);
        end
    endtask : chk_load
    task automatic chk_flags();
        logic [15:0] want;
        want = {12'h000, 1'(m_en != 0 && m_fired == 0), 1'(m_done != 0),
            1'(m_fired != 0), 1'(m_pin != 0 && m_fired == 0)};
        chk(16'({en, done, hrq, pin_n}), want, want);
    endtask : chk_flags
    task automatic pulse(input int k);
        case (k)
            0: svc = 1;
            1: dis = 1;
            default: eoi = 1;
        endcase
        @(negedge clk_sys);
        {svc, dis, eoi} = 3'h0;
    endtask : pulse
    task automatic do_reset();
        rst_n = 0;
        repeat (6) @(negedge clk_sys);
        chk(cnt, 0, 0);
        chk(16'({en, done, hrq, pin_n}), 8, 8);
        chk_flags();
        rst_n = 1;
    endtask : do_reset
    task automatic conclude();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        repeat (40) @(negedge clk_sys);
        chk(cnt, 19, 21);
        for (int i = 0; i < 4; i++) begin
            rel = 8'($random(seed));
            @(negedge clk_sys);
            pulse(0);
            chk(cnt, {rel, 8'h00}, {rel, 8'h00});
            chk_load();
        end
        pulse(2);
        chk(16'({done, pin_n}), 3, 3);
        chk_flags();
        pulse(1);
        chk(16'(en), 1, 1);
        chk_flags();
        rel = 8'hff;
        @(negedge clk_sys);
        pulse(0);
        chk_load();
        n = 0;
        exp_n = 256 * DIV_FAST;
        while (hrq !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        chk(16'(n), exp_n - 2, exp_n + 2);
        chk(16'({en, hrq, pin_n}), 2, 2);
        m_fired = 1;
        chk_flags();
        do_reset();
        slow = 1;
        @(negedge clk_sys);
        pulse(0);
        chk_load();
        repeat (256) @(negedge clk_sys);
        chk(cnt, 16'hff01, 16'hff03);
        slow = 0;
        do_reset();
        pulse(0);
        chk_load();
        pulse(1);
        repeat (600) @(negedge clk_sys);
        chk(16'({en, hrq}), 0, 0);
        chk_flags();
        conclude();
    end
    initial begin
        #200000;
        error_cnt++;
        $display("BAD %0t timeout", $time);
        conclude();
    end
endmodule : fail_safe_watchdog_timer_tb_top
